//--- common/dcm_pkg.sv
// Notes on behaviour
// - mode bits 6..4 divide the fast oscillator by 1 to 128; reset is divide by 1.
// - writing 0 to mode bit 7 selects the slow clock (Slow mode); resets to 1.
// - writing 1 to mode bit 7 in Slow mode returns to the divided fast clock.
// - in Slow mode the fast oscillator is off and the divided clock is inactive.
// - mode bit 3 enables the real-time-clock divider; it resets to enabled.
// - writing 0 to mode bit 2 clears the real-time-clock counter; bit reads 1.
// - the slow clock drives a 14-bit divider with taps 16 kHz down to 2 Hz.
// - after reset the block is in Normal mode, fast oscillator on, fast CPU clock.
// - writing 0x5a to the sleep register from Normal or Slow enters Standby or Halt.
// - after the sleep command the CPU clock stays stopped until a wake-up.
// - Standby keeps slow clock and divider; wakes on key, timers, real timers, external.
// - Halt stops both oscillators and the divider; only key or external wakes.
// - Slow to Normal waits 512 fast oscillator cycles before using the fast clock.
// - a fixed option picks slow RC or slow crystal; fast source is the fast RC.
// - the sleep command enters Standby with divider enabled, Halt otherwise.
// - after wake-up the block resumes Normal if mode bit 7 is 1, else Slow.
// - after wake-up execution waits 512 fast cycles into Normal, else 4 slow RC or 1024 crystal cycles, to settle.
package dcm_pkg;

    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 32;

    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_SLEEP = 8'h15;
    localparam logic [7:0] IDX_MODE = 8'h17;
    localparam logic [7:0] IDX_STATUS = 8'h18;

    // mode register fields
    localparam int unsigned MODE_SEL_BIT = 7;
    localparam int unsigned MODE_DIV_HI = 6;
    localparam int unsigned MODE_DIV_LO = 4;
    localparam int unsigned MODE_RTC_EN_BIT = 3;
    localparam int unsigned MODE_RTC_CLR_BIT = 2;

    // reset values of the mode register fields
    localparam logic MODE_SEL_RST = 1'b1;
    localparam logic [2:0] MODE_DIV_RST = 3'h0;
    localparam logic MODE_RTC_EN_RST = 1'b1;

    localparam logic [7:0] SLEEP_KEY = 8'h5a;

    localparam int unsigned FAST_DIV_W = 7;
    localparam int unsigned RTC_W = 14;
    localparam int unsigned STAB_W = 11;

    // settling counts, in oscillator cycles
    localparam logic [STAB_W-1:0] FAST_STAB_CYC = 11'd512;
    localparam logic [STAB_W-1:0] SLOW_RC_STAB_CYC = 11'd4;
    localparam logic [STAB_W-1:0] SLOW_XTAL_STAB_CYC = 11'd1024;

    typedef enum logic [2:0] {
        ST_NORMAL,
        ST_SLOW,
        ST_FAST_WARM,
        ST_STANDBY,
        ST_HALT,
        ST_WAKE_WARM
    } dcm_state_t;

endpackage : dcm_pkg

//--- rtl/dcm_tap_counter.sv
`timescale 1ns/1ps
`default_nettype none
module dcm_tap_counter
    import dcm_pkg::*;
#(
    parameter int unsigned W = 8
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic src_lvl_i,
    input wire logic en_i,
    input wire logic clr_i,
    output logic lvl_o,
    output logic rise_o,
    output logic [W-1:0] cnt_o
);

    typedef struct packed {
        logic lvl;
        logic rise;
        logic [W-1:0] cnt;
    } dcm_tap_t;

    dcm_tap_t q;
    dcm_tap_t d;

    always_comb
    begin
        d = q;
        d.lvl = src_lvl_i;
        d.rise = src_lvl_i & ~q.lvl;
        if (clr_i)
        begin
            d.cnt = '0;
        end
        else if (en_i && src_lvl_i && !q.lvl)
        begin
            d.cnt = q.cnt + {{(W-1){1'b0}}, 1'b1};
        end
        if (srst_i)
        begin
            d = '0;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        q <= d;
    end

    assign lvl_o = q.lvl;
    assign rise_o = q.rise;
    assign cnt_o = q.cnt;

endmodule : dcm_tap_counter
`default_nettype wire

//--- rtl/dcm_mode_ctrl.sv
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dcm_mode_ctrl
    import dcm_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic fast_osc_clock_i,
    input wire logic slow_osc_clock_i,
    input wire logic slow_src_xtal_i,
    input wire logic wake_key_i,
    input wire logic wake_ext_i,
    input wire logic [2:0] wake_timer_i,
    input wire logic [1:0] wake_real_timer_i,
    output logic fast_osc_en_o,
    output logic slow_osc_en_o,
    output logic divided_fast_clock_o,
    output logic cpu_clock_o,
    output logic cpu_run_o,
    output logic [RTC_W-1:0] rtc_taps_o,
    output logic [2:0] op_state_o
);

    typedef struct packed {
        logic wait_q;
        logic [DATA_W-1:0] rdata;
        logic cpu_sel;
        logic [2:0] div;
        logic rtc_en;
        logic rtc_clr;
        logic xtal;
        dcm_state_t st;
        logic [STAB_W-1:0] stab;
        logic fast_en;
        logic slow_en;
        logic div_clk;
        logic cpu_clk;
        logic src_slow;
        logic follow;
        logic run;
    } dcm_ctrl_t;

    dcm_ctrl_t q;
    dcm_ctrl_t d;

    logic fast_lvl;
    logic fast_rise;
    logic [FAST_DIV_W-1:0] fast_cnt;
    logic slow_lvl;
    logic slow_rise;
    logic [RTC_W-1:0] rtc_cnt;
    logic rtc_run;

    ////////////////////////////////////////////////////////////////////////////////
    // oscillator edge counters

    dcm_tap_counter #(
        .W(FAST_DIV_W)
    ) u_fast_div (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .src_lvl_i(fast_osc_clock_i),
        .en_i(q.fast_en),
        .clr_i(~q.fast_en),
        .lvl_o(fast_lvl),
        .rise_o(fast_rise),
        .cnt_o(fast_cnt)
    );

    // divider runs on the slow clock unless disabled or halted
    assign rtc_run = q.slow_en & q.rtc_en & (q.st != ST_HALT);

    dcm_tap_counter #(
        .W(RTC_W)
    ) u_rtc_div (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .src_lvl_i(slow_osc_clock_i),
        .en_i(rtc_run),
        .clr_i(q.rtc_clr),
        .lvl_o(slow_lvl),
        .rise_o(slow_rise),
        .cnt_o(rtc_cnt)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // register access and mode sequencing

    logic req;
    logic acc;
    logic hit_mode;
    logic hit_sleep;
    logic hit_status;
    logic wr_mode;
    logic sleep_cmd;
    logic any_wake;
    logic want_slow;
    logic cur_lvl;
    logic new_lvl;
    logic [STAB_W-1:0] wake_target;
    logic wake_tick;
    logic [7:0] mode_rd;
    logic [7:0] status_rd;

    always_comb
    begin
        d = q;
        req = avs_read_i | avs_write_i;
        acc = req & ~q.wait_q;
        hit_mode = (avs_address_i == {IDX_MODE, 2'b00});
        hit_sleep = (avs_address_i == {IDX_SLEEP, 2'b00});
        hit_status = (avs_address_i == {IDX_STATUS, 2'b00});
        wr_mode = acc & avs_write_i & hit_mode & avs_byteenable_i[0];
        sleep_cmd = acc & avs_write_i & hit_sleep & avs_byteenable_i[0]
            & (avs_writedata_i[7:0] == SLEEP_KEY)
            & ((q.st == ST_NORMAL) | (q.st == ST_SLOW));
        mode_rd = {q.cpu_sel, q.div, q.rtc_en, 1'b1, 2'b00};
        status_rd = {1'b0, q.xtal, q.slow_en, q.fast_en, q.src_slow, q.st};

        // one wait state: answer is prepared, then waitrequest drops for one edge
        if (req && q.wait_q)
        begin
            d.wait_q = 1'b0;
            d.rdata = '0;
            if (hit_mode)
            begin
                d.rdata = {24'h0, mode_rd};
            end
            else if (hit_status)
            begin
                d.rdata = {24'h0, status_rd};
            end
        end
        else
        begin
            d.wait_q = 1'b1;
        end

        d.rtc_clr = wr_mode & ~avs_writedata_i[MODE_RTC_CLR_BIT];
        if (wr_mode)
        begin
            d.cpu_sel = avs_writedata_i[MODE_SEL_BIT];
            d.div = avs_writedata_i[MODE_DIV_HI:MODE_DIV_LO];
            d.rtc_en = avs_writedata_i[MODE_RTC_EN_BIT];
        end

        any_wake = wake_key_i | wake_ext_i;
        if (q.st == ST_STANDBY)
        begin
            any_wake = any_wake | (|wake_timer_i) | (|wake_real_timer_i);
        end
        wake_target = q.cpu_sel ? FAST_STAB_CYC
            : (q.xtal ? SLOW_XTAL_STAB_CYC : SLOW_RC_STAB_CYC);
        wake_tick = q.cpu_sel ? fast_rise : slow_rise;

        case (q.st)
            ST_NORMAL, ST_SLOW:
            begin
                if (sleep_cmd)
                begin
                    d.st = q.rtc_en ? ST_STANDBY : ST_HALT;
                end
                else if (q.st == ST_NORMAL && !q.cpu_sel && !q.div_clk)
                begin
                    d.st = ST_SLOW;
                end
                else if (q.st == ST_SLOW && q.cpu_sel)
                begin
                    d.st = ST_FAST_WARM;
                    d.stab = '0;
                end
            end
            ST_FAST_WARM:
            begin
                if (!q.cpu_sel)
                begin
                    d.st = ST_SLOW;
                end
                else if (fast_rise)
                begin
                    d.stab = q.stab + 11'd1;
                    if (q.stab == FAST_STAB_CYC - 11'd1)
                    begin
                        d.st = ST_NORMAL;
                    end
                end
            end
            ST_STANDBY, ST_HALT:
            begin
                if (any_wake)
                begin
                    d.st = ST_WAKE_WARM;
                    d.stab = '0;
                end
            end
            ST_WAKE_WARM:
            begin
                if (wake_tick)
                begin
                    d.stab = q.stab + 11'd1;
                    if (q.stab == wake_target - 11'd1)
                    begin
                        d.st = q.cpu_sel ? ST_NORMAL : ST_SLOW;
                    end
                end
            end
            default:
            begin
                d.st = ST_NORMAL;
            end
        endcase

        // fast oscillator only where the fast clock is used or warming
        d.fast_en = (d.st == ST_NORMAL) | (d.st == ST_FAST_WARM)
            | ((d.st == ST_WAKE_WARM) & d.cpu_sel);
        d.slow_en = (d.st != ST_HALT);
        d.run = (d.st == ST_NORMAL) | (d.st == ST_SLOW) | (d.st == ST_FAST_WARM);

        if (!d.fast_en)
        begin
            d.div_clk = 1'b0;
        end
        else if (q.div == 3'h0)
        begin
            d.div_clk = fast_lvl;
        end
        else
        begin
            d.div_clk = fast_cnt[q.div - 3'd1];
        end

        // clock mux: leave a source only while low, join a new one only while low
        want_slow = (q.st != ST_NORMAL);
        cur_lvl = q.src_slow ? slow_lvl : q.div_clk;
        new_lvl = want_slow ? slow_lvl : q.div_clk;
        if (q.follow)
        begin
            d.cpu_clk = cur_lvl;
            if (((q.src_slow != want_slow) || !q.run) && !cur_lvl)
            begin
                d.follow = 1'b0;
                d.cpu_clk = 1'b0;
            end
        end
        else
        begin
            d.cpu_clk = 1'b0;
            if (q.run && !new_lvl)
            begin
                d.src_slow = want_slow;
                d.follow = 1'b1;
            end
        end

        if (srst_i)
        begin
            d = '0;
            d.wait_q = 1'b1;
            d.cpu_sel = MODE_SEL_RST;
            d.div = MODE_DIV_RST;
            d.rtc_en = MODE_RTC_EN_RST;
            d.xtal = slow_src_xtal_i;
            d.st = ST_NORMAL;
            d.fast_en = 1'b1;
            d.slow_en = 1'b1;
            d.run = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        q <= d;
    end

    assign avs_readdata_o = q.rdata;
    assign avs_waitrequest_o = q.wait_q;
    assign fast_osc_en_o = q.fast_en;
    assign slow_osc_en_o = q.slow_en;
    assign divided_fast_clock_o = q.div_clk;
    assign cpu_clock_o = q.cpu_clk;
    assign cpu_run_o = q.run;
    assign rtc_taps_o = rtc_cnt;
    assign op_state_o = q.st;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    a_sleep_to_standby: assert property (sleep_cmd && q.rtc_en |=> q.st == ST_STANDBY)
        else $error("sleep with divider enabled did not enter standby");
    a_sleep_to_halt: assert property (sleep_cmd && !q.rtc_en |=> q.st == ST_HALT)
        else $error("sleep with divider disabled did not enter halt");
    a_slow_fast_off: assert property (q.st == ST_SLOW |-> !fast_osc_en_o && !divided_fast_clock_o)
        else $error("fast clock active in slow mode");
    a_halt_all_off: assert property (q.st == ST_HALT && $past(q.st) == ST_HALT
        |-> !slow_osc_en_o && !fast_osc_en_o && $stable(rtc_taps_o))
        else $error("oscillator or divider active in halt");
    a_gated_clock_low: assert property (!q.follow |-> !cpu_clock_o)
        else $error("cpu clock high while gated");
    a_switch_while_low: assert property ($changed(q.src_slow) |-> !cpu_clock_o && !$past(cpu_clock_o))
        else $error("cpu clock source changed while high");
    a_rtc_clear: assert property (wr_mode && !avs_writedata_i[MODE_RTC_CLR_BIT]
        |-> ##2 rtc_taps_o == '0)
        else $error("divider not cleared");
    a_mode_bit2_high: assert property (!avs_waitrequest_o && avs_read_i && hit_mode
        |-> avs_readdata_o[MODE_RTC_CLR_BIT])
        else $error("clear bit did not read as one");
    a_reset_normal: assert property ($fell(srst_i) |-> q.st == ST_NORMAL && fast_osc_en_o
        && q.cpu_sel && q.div == 3'h0)
        else $error("reset did not give normal mode");
    a_fast_warm_count: assert property (q.st == ST_FAST_WARM ##1 q.st == ST_NORMAL
        |-> $past(q.stab) == FAST_STAB_CYC - 11'd1)
        else $error("fast settling count wrong");
    a_wake_target: assert property (q.st == ST_WAKE_WARM ##1 q.st != ST_WAKE_WARM
        |-> q.st == (q.cpu_sel ? ST_NORMAL : ST_SLOW))
        else $error("wrong mode after wake-up");

endmodule : dcm_mode_ctrl
`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dcm_pkg::*;
    localparam logic [9:0] A_SLP = {IDX_SLEEP, 2'b00};
    localparam logic [9:0] A_MODE = {IDX_MODE, 2'b00};
    localparam logic [9:0] A_STAT = {IDX_STATUS, 2'b00};
    logic clk, srst, rd, wr, fosc, sosc, xtal, wkey, wext, wait_o, fen, sen, dfc, cpuc, run;
    logic pdf, pcc;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdat, rdat, r;
    logic [3:0] be;
    logic [2:0] wtim, st;
    logic [1:0] wrt;
    logic [RTC_W-1:0] taps, t0;
    int err_total, total_checks, cyc, rng, mode_m, k, ndf, ncc, a, b;

    dcm_mode_ctrl dut_u (
        .core_clk_i(clk), .srst_i(srst), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o), .fast_osc_clock_i(fosc),
        .slow_osc_clock_i(sosc), .slow_src_xtal_i(xtal), .wake_key_i(wkey),
        .wake_ext_i(wext), .wake_timer_i(wtim), .wake_real_timer_i(wrt),
        .fast_osc_en_o(fen), .slow_osc_en_o(sen), .divided_fast_clock_o(dfc),
        .cpu_clock_o(cpuc), .cpu_run_o(run), .rtc_taps_o(taps), .op_state_o(st)
    );

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // oscillators, edge counters and the hang limit
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (fen === 1'b1)
            fosc <= ~fosc;
        if (cyc % 4 == 3 && sen === 1'b1)
            sosc <= ~sosc;
        pdf <= dfc;
        pcc <= cpuc;
        if (dfc === 1'b1 && pdf === 1'b0)
            ndf <= ndf + 1;
        if (cpuc === 1'b1 && pcc === 1'b0)
            ncc <= ncc + 1;
        if (cyc == 40000)
        begin
            err_total++;
            report_and_stop();
        end
    end

    function automatic int xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xs

    task chk(input logic [31:0] got, input logic [31:0] e, input string m);
        total_checks++;
        if (got !== e)
        begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, e);
        end
    endtask : chk

    task near(input int got, input int e, input string m);
        chk(32'(got >= e - 2 && got <= e + 2), 32'h1, m);
    endtask : near

    // one Avalon transfer; request held until waitrequest is sampled low
    task bus(input logic w, input logic [9:0] ad, input logic [7:0] d);
        int t;
        t = 0;
        @(posedge clk);
        addr <= ad;
        wdat <= {24'(xs()), d};
        rd <= !w;
        wr <= w;
        do
        begin
            @(posedge clk);
            t++;
        end
        while (wait_o !== 1'b0 && t < 50);
        r = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (t >= 50)
            chk(32'h0, 32'h1, "bus no answer");
    endtask : bus

    // model: bit 2 reads 1, bits 1:0 read 0
    task wmode(input logic [7:0] d);
        bus(1'b1, A_MODE, d);
        mode_m = (d & 8'hf8) | 8'h04;
    endtask : wmode

    task wait_st(input logic [2:0] e, input int lim);
        int t;
        t = 0;
        while (st !== e && t < lim)
        begin
            @(posedge clk);
            t++;
        end
        chk(st, e, "state");
    endtask : wait_st

    task tend(input string n);
        $display("test %s done, checks %0d", n, total_checks);
    endtask : tend

    task report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
        begin
            $display("Simulation passed");
        end
        else
        begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {rd, wr, fosc, sosc, xtal, wkey, wext, pdf, pcc} = '0;
        {wtim, wrt, addr, wdat} = '0;
        be = 4'hf;
        rng = 9;
        mode_m = 8'h8c;
        srst = 1'b1;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        chk(st, 3'h0, "reset state");
        chk({fen, run}, 2'h3, "reset run");
        bus(1'b0, A_MODE, 8'h00);
        chk(r, mode_m, "mode reset");
        bus(1'b0, A_STAT, 8'h00);
        chk(r, 32'h30, "status normal");
        addr <= {2'b10, 6'(xs()), 2'b00};
        bus(1'b1, {2'b10, 6'(xs()), 2'b00}, 8'hff);
        bus(1'b0, {2'b11, 6'(xs()), 2'b00}, 8'h00);
        chk(r, 32'h0, "unmapped read");
        be <= 4'he;
        bus(1'b1, A_MODE, 8'h70);
        be <= 4'hf;
        bus(1'b0, A_MODE, 8'h00);
        chk(r, mode_m, "masked write");
        tend("reset");
        for (k = 0; k < 8; k++)
        begin
            wmode(8'h88 | 8'(k << 4) | 8'(xs() & 3));
            bus(1'b0, A_MODE, 8'h00);
            chk(r, mode_m, "mode readback");
            repeat (64) @(posedge clk);
            a = ndf;
            b = ncc;
            repeat (1024) @(posedge clk);
            near(ndf - a, 512 >> k, "div rate");
            near(ncc - b, 512 >> k, "cpu fast rate");
        end
        tend("divider");
        wmode(8'h0c);
        wait_st(3'h1, 20);
        chk(fen, 1'b0, "fast osc off");
        repeat (16) @(posedge clk);
        bus(1'b0, A_STAT, 8'h00);
        chk(r, 32'h29, "status slow");
        repeat (8) @(posedge clk);
        a = ndf;
        b = ncc;
        t0 = taps;
        repeat (800) @(posedge clk);
        chk(ndf - a, 0, "div clock idle");
        near(ncc - b, 100, "cpu slow rate");
        near(int'(RTC_W'(taps - t0)), 100, "rtc rate");
        wmode(8'h08);
        repeat (3) @(posedge clk);
        chk(32'(taps <= 1), 32'h1, "rtc clear");
        wmode(8'h8c);
        wait_st(3'h2, 10);
        bus(1'b1, A_SLP, SLEEP_KEY);
        @(posedge clk);
        chk(st, 3'h2, "no sleep in warm-up");
        repeat (900) @(posedge clk);
        chk(st, 3'h2, "still warming");
        wait_st(3'h0, 300);
        tend("slow");
        wmode(8'h84);
        repeat (2) @(posedge clk);
        t0 = taps;
        repeat (100) @(posedge clk);
        chk(taps, t0, "rtc disabled");
        bus(1'b1, A_SLP, 8'h5b);
        repeat (3) @(posedge clk);
        chk(st, 3'h0, "bad sleep key");
        bus(1'b1, A_SLP, SLEEP_KEY);
        wait_st(3'h4, 5);
        repeat (4) @(posedge clk);
        chk({fen, sen, run, cpuc}, 4'h0, "halt clocks");
        wtim <= 3'(xs() | 1);
        wrt <= 2'h3;
        repeat (30) @(posedge clk);
        chk(st, 3'h4, "halt timer wake");
        {wtim, wrt} <= '0;
        wkey <= 1'b1;
        wait_st(3'h5, 5);
        wkey <= 1'b0;
        chk(run, 1'b0, "wake warm stalls");
        repeat (900) @(posedge clk);
        chk(st, 3'h5, "wake warm long");
        wait_st(3'h0, 300);
        tend("halt");
        wmode(8'h8c);
        for (k = 0; k < 7; k++)
        begin
            bus(1'b1, A_SLP, SLEEP_KEY);
            wait_st(3'h3, 5);
            chk({fen, sen, run}, 3'h2, "standby clocks");
            t0 = taps;
            repeat (40) @(posedge clk);
            chk(32'(taps != t0), 32'h1, "rtc runs");
            {wext, wkey, wrt, wtim} <= 7'(1 << k);
            wait_st(3'h5, 5);
            {wext, wkey, wrt, wtim} <= '0;
            wait_st(3'h0, 1100);
        end
        tend("standby");
        wmode(8'h0c);
        wait_st(3'h1, 20);
        bus(1'b1, A_SLP, SLEEP_KEY);
        wait_st(3'h3, 5);
        wext <= 1'b1;
        wait_st(3'h5, 5);
        wext <= 1'b0;
        repeat (16) @(posedge clk);
        chk(st, 3'h5, "rc settle");
        wait_st(3'h1, 100);
        chk(run, 1'b1, "slow resumes");
        tend("slow wake");
        xtal <= 1'b1;
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        mode_m = 8'h8c;
        chk(st, 3'h0, "second reset");
        bus(1'b0, A_STAT, 8'h00);
        chk(r, 32'h70, "status crystal");
        bus(1'b0, A_MODE, 8'h00);
        chk(r, mode_m, "mode after reset");
        repeat (8) @(posedge clk);
        wmode(8'h0c);
        wait_st(3'h1, 20);
        bus(1'b1, A_SLP, SLEEP_KEY);
        wait_st(3'h3, 5);
        wkey <= 1'b1;
        wait_st(3'h5, 5);
        wkey <= 1'b0;
        repeat (8000) @(posedge clk);
        chk(st, 3'h5, "crystal settle");
        wait_st(3'h1, 400);
        tend("crystal");
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
